/* File: hdl/dio_pkg.sv */
// constants, types and register map of the digital i/o signal router
package dio_pkg;
  localparam int IMG_W = 32;
  localparam int NUM_PIN = 16;
  localparam int NUM_OUT = 2;
  localparam int NUM_ROUTE = NUM_OUT + 1;
  localparam int TICK_W = 17;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_PERIOD_NS = 1000000;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  // register word addresses
  localparam logic [7:0] ADDR_IN_SPECIAL = 8'h00;
  localparam logic [7:0] ADDR_IN_ROUTE_EN = 8'h01;
  localparam logic [7:0] ADDR_OUT_UNUSED = 8'h02;
  localparam logic [7:0] ADDR_OUT_POL = 8'h03;
  localparam logic [7:0] ADDR_OUT_MAN_EN = 8'h04;
  localparam logic [7:0] ADDR_OUT_MAN_VAL = 8'h05;
  localparam logic [7:0] ADDR_OUT_APPLIED = 8'h06;
  localparam logic [7:0] ADDR_OUT_ROUTE_EN = 8'h07;
  localparam logic [7:0] ADDR_LED_CTRL = 8'h08;
  localparam logic [7:0] ADDR_OUT_IMAGE = 8'h09;
  localparam logic [7:0] ADDR_CTRL_WORD = 8'h0a;
  localparam logic [7:0] ADDR_IN_IMAGE = 8'h0b;
  localparam logic [7:0] ADDR_REL_STATE = 8'h0c;
  localparam logic [7:0] ADDR_IN_ROUTE_BASE = 8'h20;
  localparam logic [7:0] ADDR_OUT_ROUTE_BASE = 8'h40;
  localparam logic [7:0] ADDR_OUT_ROUTE_LAST = ADDR_OUT_ROUTE_BASE + 8'(NUM_ROUTE - 1);
  // input source codes; bit 7 of a code inverts the source
  localparam logic [6:0] ISRC_PIN_LAST = 7'h10;
  localparam logic [6:0] ISRC_ENC_A = 7'h44;
  localparam logic [6:0] ISRC_ENC_B = 7'h45;
  localparam logic [6:0] ISRC_ENC_IDX = 7'h46;
  localparam logic [6:0] ISRC_NET = 7'h48;
  localparam int ISRC_INV_BIT = 7;
  // output source codes (high byte of a route entry)
  localparam logic [7:0] OSRC_ONE = 8'h00;
  localparam logic [7:0] OSRC_ENC_FIRST = 8'h02;
  localparam logic [7:0] OSRC_POS_LAST = 8'h0f;
  localparam logic [7:0] OSRC_PWM = 8'h10;
  localparam logic [7:0] OSRC_PWM_INV = 8'h11;
  localparam int OGATE_INV_BIT = 7;
  // bit positions
  localparam int BRAKE_BIT = 0;
  localparam int RELEASE_BIT = 3;
  localparam int LEVEL_BIT0 = 16;
  localparam int LED_GREEN_BIT = 0;
  localparam int LED_RED_BIT = 1;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0;
  localparam logic [7:0] RST_IN_SEL = 8'h00;
  localparam logic [15:0] RST_ROUTE = 16'h0100;

  typedef struct packed {
    logic [7:0] src;
    logic [7:0] gate;
  } dio_route_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dio_bus_req_type;

  typedef struct packed {
    logic enc_a;
    logic enc_b;
    logic enc_idx;
  } dio_enc_type;

  typedef enum logic [1:0] {
    REL_OFF = 2'b00,
    REL_RUN = 2'b01,
    REL_STOP = 2'b10
  } dio_rel_state_type;
endpackage

/* File: hdl/dio_router.sv */
// digital i/o signal router: input routing, motion release, output drive and routing
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dio_router #(
  parameter int unsigned SAMPLE_CYCLES_P = dio_pkg::SAMPLE_CYCLES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire dio_pkg::dio_bus_req_type bus_req_i,
  output logic [31:0] bus_rdata_o,
  // machine pins, asynchronous
  input wire logic [dio_pkg::NUM_PIN-1:0] pin_in_i,
  input wire dio_pkg::dio_enc_type enc_i,
  // controller side, same clock
  input wire logic net_active_i,
  input wire logic pwm_i,
  input wire logic [31:0] encoder_count_value_i,
  input wire logic [31:0] actual_position_value_i,
  // output drivers and leds
  output logic [dio_pkg::NUM_OUT-1:0] out_level_o,
  output logic brake_o,
  output logic pwm_pin_o,
  output logic led_green_en_o,
  output logic led_red_en_o,
  // motion release and input image
  output logic motion_release_o,
  output logic interlock_fault_o,
  output logic [31:0] input_image_word_o
);
  import dio_pkg::*;

  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] in_special;
  logic [31:0] pol_mask;
  logic [31:0] man_en;
  logic [31:0] man_val;
  logic [31:0] out_image;
  logic [31:0] ctrl_word;
  logic [31:0] applied;
  logic [31:0] next_applied;
  logic [31:0] next_in_image;
  logic [31:0] rd_word;
  logic in_route_en;
  logic out_route_en;
  logic route_on_write;
  logic [1:0] led_ctrl;
  logic [7:0] in_sel [IMG_W];
  dio_route_type out_route [NUM_ROUTE];
  logic [18:0] sync1;
  logic [18:0] sync2;
  logic [TICK_W-1:0] tick_cnt;
  logic tick;
  logic [1:0][6:0] pv_pulse;
  logic next_pwm_pin;
  dio_rel_state_type rel_state;
  dio_rel_state_type next_rel_state;

  assign wr = bus_req_i.wr;
  assign rd = bus_req_i.rd;
  assign addr = bus_req_i.addr;
  assign wdata = bus_req_i.wdata;
  assign led_green_en_o = led_ctrl[LED_GREEN_BIT];
  assign led_red_en_o = led_ctrl[LED_RED_BIT];
  assign route_on_write = wr && addr == ADDR_IN_ROUTE_EN && wdata[0] && !in_route_en;

  // input source: undefined codes stay low even when the invert bit is set
  function automatic logic in_src_level(input logic [7:0] code, input logic [18:0] src,
                                        input logic net);
    logic v;
    logic def;
    v = 1'b0;
    def = 1'b1;
    if (code[6:0] >= 7'h01 && code[6:0] <= ISRC_PIN_LAST) begin
      v = src[4'(code[6:0] - 7'h01)];
    end else begin
      case (code[6:0])
        7'h00: v = 1'b0;
        ISRC_ENC_A: v = src[18];
        ISRC_ENC_B: v = src[17];
        ISRC_ENC_IDX: v = src[16];
        ISRC_NET: v = net;
        default: def = 1'b0;
      endcase
    end
    return def & (v ^ code[ISRC_INV_BIT]);
  endfunction

  // routed output: source gated by one control word bit
  function automatic logic route_level(input dio_route_type r, input logic [31:0] ctrl,
                                       input logic [13:0] pulses, input logic pwm);
    logic src;
    logic gate;
    src = 1'b0;
    gate = (r.gate[6:5] == 2'b00) ? ctrl[r.gate[4:0]] : 1'b0;
    if (r.src == OSRC_ONE) begin
      src = 1'b1;
    end else if (r.src >= OSRC_ENC_FIRST && r.src <= OSRC_POS_LAST) begin
      src = pulses[4'(r.src - OSRC_ENC_FIRST)];
    end else if (r.src == OSRC_PWM) begin
      src = pwm;
    end else if (r.src == OSRC_PWM_INV) begin
      src = ~pwm;
    end
    return src & (gate ^ r.gate[OGATE_INV_BIT]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_special <= RST_WORD;
      in_route_en <= 1'b0;
      pol_mask <= RST_WORD;
      man_en <= RST_WORD;
      man_val <= RST_WORD;
      out_route_en <= 1'b0;
      led_ctrl <= 2'b00;
      out_image <= RST_WORD;
      ctrl_word <= RST_WORD;
    end else if (wr) begin
      case (addr)
        ADDR_IN_SPECIAL: in_special <= wdata;
        ADDR_IN_ROUTE_EN: in_route_en <= wdata[0];
        ADDR_OUT_POL: pol_mask <= wdata;
        ADDR_OUT_MAN_EN: man_en <= wdata;
        ADDR_OUT_MAN_VAL: man_val <= wdata;
        ADDR_OUT_ROUTE_EN: out_route_en <= wdata[0];
        ADDR_LED_CTRL: led_ctrl <= wdata[1:0];
        ADDR_OUT_IMAGE: out_image <= wdata;
        ADDR_CTRL_WORD: ctrl_word <= wdata;
        default: ;
      endcase
    end
  end

  // one selector per image bit, preloaded on enable to mimic the plain mapping
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int n = 0; n < IMG_W; n++) begin
        in_sel[n] <= RST_IN_SEL;
      end
    end else if (route_on_write) begin
      for (int n = 0; n < IMG_W; n++) begin
        in_sel[n] <= (n < LEVEL_BIT0) ? 8'(n + 1) : 8'(n - LEVEL_BIT0 + 1);
      end
    end else if (wr && addr[7:5] == ADDR_IN_ROUTE_BASE[7:5]) begin
      in_sel[addr[4:0]] <= wdata[7:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < NUM_ROUTE; k++) begin
        out_route[k] <= RST_ROUTE;
      end
    end else if (wr && addr >= ADDR_OUT_ROUTE_BASE && addr <= ADDR_OUT_ROUTE_LAST) begin
      out_route[addr[1:0]] <= wdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register reads: data in the cycle after the strobe only

  always_comb begin
    rd_word = '0;
    case (addr)
      ADDR_IN_SPECIAL: rd_word = in_special;
      ADDR_IN_ROUTE_EN: rd_word = {31'h0, in_route_en};
      ADDR_OUT_UNUSED: rd_word = '0;
      ADDR_OUT_POL: rd_word = pol_mask;
      ADDR_OUT_MAN_EN: rd_word = man_en;
      ADDR_OUT_MAN_VAL: rd_word = man_val;
      ADDR_OUT_APPLIED: rd_word = applied;
      ADDR_OUT_ROUTE_EN: rd_word = {31'h0, out_route_en};
      ADDR_LED_CTRL: rd_word = {30'h0, led_ctrl};
      ADDR_OUT_IMAGE: rd_word = out_image;
      ADDR_CTRL_WORD: rd_word = ctrl_word;
      ADDR_IN_IMAGE: rd_word = input_image_word_o;
      ADDR_REL_STATE: rd_word = {30'h0, rel_state};
      default: begin
        if (addr[7:5] == ADDR_IN_ROUTE_BASE[7:5]) begin
          rd_word = {24'h0, in_sel[addr[4:0]]};
        end else if (addr >= ADDR_OUT_ROUTE_BASE && addr <= ADDR_OUT_ROUTE_LAST) begin
          rd_word = {16'h0, out_route[addr[1:0]]};
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_rdata_o <= '0;
    end else begin
      bus_rdata_o <= rd ? rd_word : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // input sampling and input image

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {enc_i, pin_in_i};
      sync2 <= sync1;
    end
  end

  // the image samples sync2 only on a tick; a short glitch reaches it only if present in the tick cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == TICK_W'(SAMPLE_CYCLES_P - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  always_comb begin
    next_in_image = {sync2[15:0], sync2[15:0]};
    if (in_route_en) begin
      for (int n = 0; n < IMG_W; n++) begin
        next_in_image[n] = in_src_level(in_sel[n], sync2, net_active_i);
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      input_image_word_o <= RST_WORD;
    end else if (tick) begin
      input_image_word_o <= next_in_image;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // motion release

  always_comb begin
    next_rel_state = rel_state;
    case (rel_state)
      REL_OFF, REL_RUN, REL_STOP: begin
        if (!in_special[RELEASE_BIT]) begin
          next_rel_state = REL_OFF;
        end else if (input_image_word_o[RELEASE_BIT]) begin
          next_rel_state = REL_RUN;
        end else begin
          next_rel_state = REL_STOP;
        end
      end
      default: next_rel_state = REL_OFF;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rel_state <= REL_OFF;
      motion_release_o <= 1'b1;
      interlock_fault_o <= 1'b0;
    end else begin
      rel_state <= next_rel_state;
      motion_release_o <= next_rel_state != REL_STOP;
      // one pulse on entry, so the fault reaction fires once per drop
      interlock_fault_o <= next_rel_state == REL_STOP && rel_state != REL_STOP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // count pulses: one pulse per single step up or down, divided by the counter

  for (genvar g = 0; g < 2; g++) begin : g_pulse
    logic [31:0] cur;
    logic [31:0] prev;
    logic [5:0] cnt;
    logic up;
    logic dn;
    logic [5:0] next_cnt;
    assign cur = (g == 0) ? encoder_count_value_i : actual_position_value_i;
    assign up = cur == prev + 32'h1;
    assign dn = cur == prev - 32'h1;
    assign next_cnt = up ? cnt + 6'h1 : (dn ? cnt - 6'h1 : cnt);
    // jumps larger than one step per clock are not counted
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        prev <= '0;
        cnt <= '0;
      end else begin
        prev <= cur;
        cnt <= next_cnt;
      end
    end
    for (genvar k = 0; k < 7; k++) begin : g_div
      assign pv_pulse[g][k] = (up || dn) &&
                              ((next_cnt & 6'((7'h1 << k) - 7'h1)) == 6'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output drive; outputs update every clock, far faster than 2 kHz

  always_comb begin
    next_applied = '0;
    next_pwm_pin = pwm_i;
    if (out_route_en) begin
      next_applied[BRAKE_BIT] = out_image[BRAKE_BIT];
      next_pwm_pin = route_level(out_route[0], ctrl_word, pv_pulse, pwm_i);
      for (int i = 0; i < NUM_OUT; i++) begin
        next_applied[LEVEL_BIT0 + i] =
          route_level(out_route[i + 1], ctrl_word, pv_pulse, pwm_i);
      end
    end else begin
      // bits 1 to 15 are left out: only the brake has a special function
      next_applied[BRAKE_BIT] = man_en[BRAKE_BIT] ? man_val[BRAKE_BIT] :
                                out_image[BRAKE_BIT] ^ pol_mask[BRAKE_BIT];
      for (int i = LEVEL_BIT0; i < LEVEL_BIT0 + NUM_OUT; i++) begin
        next_applied[i] = man_en[i] ? man_val[i] : out_image[i] ^ pol_mask[i];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      applied <= RST_WORD;
      out_level_o <= '0;
      brake_o <= 1'b0;
      pwm_pin_o <= 1'b0;
    end else begin
      applied <= next_applied;
      out_level_o <= next_applied[LEVEL_BIT0 +: NUM_OUT];
      brake_o <= next_applied[BRAKE_BIT];
      pwm_pin_o <= next_pwm_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_release_drop;
    rel_state == REL_RUN && in_special[RELEASE_BIT] && !input_image_word_o[RELEASE_BIT];
  endsequence

  sequence s_enc_route;
    out_route_en && out_route[2].src == OSRC_ENC_FIRST && out_route[2].gate == 8'h00 &&
      ctrl_word[0];
  endsequence

  a_release_fault: assert property (s_release_drop |=> interlock_fault_o &&
    !motion_release_o ##1 !interlock_fault_o) else $error("release drop missed");
  a_release_disabled: assert property (!in_special[RELEASE_BIT] |=>
    motion_release_o && !interlock_fault_o) else $error("release active while disabled");
  a_image_on_tick: assert property (!tick |=> $stable(input_image_word_o))
    else $error("input image changed off tick");
  a_route_preload: assert property (route_on_write |=> in_sel[0] == 8'h01 &&
    in_sel[LEVEL_BIT0 + 1] == 8'h02) else $error("selector preload wrong");
  a_in_const_high: assert property (tick && in_route_en && in_sel[6] == 8'h80 |=>
    input_image_word_o[6]) else $error("code 128 not high");
  a_in_undef_low: assert property (tick && in_route_en && in_sel[1] == 8'hb0 |=>
    !input_image_word_o[1]) else $error("undefined code not low");
  a_out_polarity: assert property (!out_route_en && !man_en[LEVEL_BIT0] |=>
    out_level_o[0] == $past(out_image[LEVEL_BIT0] ^ pol_mask[LEVEL_BIT0]))
    else $error("polarity wrong");
  a_brake_manual: assert property (!out_route_en && man_en[BRAKE_BIT] |=>
    brake_o == $past(man_val[BRAKE_BIT])) else $error("manual brake wrong");
  a_route_gate: assert property (out_route_en && out_route[1].src == OSRC_ONE &&
    out_route[1].gate[6:5] == 2'b00 |=> out_level_o[0] ==
    $past(ctrl_word[out_route[1].gate[4:0]] ^ out_route[1].gate[7]))
    else $error("route gating wrong");
  a_enc_pulse: assert property (s_enc_route |=> out_level_o[1] == $past(pv_pulse[0][0]))
    else $error("encoder pulse wrong");
  a_led_enable: assert property (wr && addr == ADDR_LED_CTRL |=>
    led_green_en_o == $past(wdata[0]) && led_red_en_o == $past(wdata[1]))
    else $error("led enable wrong");
endmodule
`default_nettype wire

/* File: test/dio_field_model.sv */
// field side model: input switches and a quadrature encoder
`timescale 1ns/1ps
`default_nettype none
module dio_field_model (
  // clock
  input wire logic core_clk_i,
  // commands from the bench
  input wire logic [dio_pkg::NUM_PIN-1:0] switch_i,
  input wire logic step_i,
  // towards the router
  output logic [dio_pkg::NUM_PIN-1:0] pin_in_o,
  output dio_pkg::dio_enc_type enc_o,
  output logic [31:0] count_o
);
  import dio_pkg::*;
  logic [NUM_PIN-1:0] sw = '0;
  logic [31:0] cnt = 32'h0;
  always @(posedge core_clk_i) begin
    sw <= switch_i;
    if (step_i) begin
      cnt <= cnt + 32'h1;
    end
  end
  // gray code, so one encoder line toggles per step, as a real disc does
  assign enc_o = '{enc_a: cnt[1], enc_b: cnt[1] ^ cnt[0], enc_idx: cnt[3:0] == 4'h0};
  assign pin_in_o = sw;
  assign count_o = cnt;
endmodule
`default_nettype wire

/* File: test/dio_router_test.sv */
// self-checking bench of the digital i/o signal router
`timescale 1ns/1ps
`default_nettype none
module dio_router_test;
  import dio_pkg::*;
  // short sample tick keeps the input path waits brief
  localparam int SC = 8;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  dio_bus_req_type bus = '0;
  logic [NUM_PIN-1:0] sw = '0;
  logic step = 1'b0;
  logic net = 1'b1;
  logic pwm = 1'b1;
  logic [NUM_PIN-1:0] pins;
  dio_enc_type enc;
  logic [31:0] cnt, rdata, img, rdv;
  logic [NUM_OUT-1:0] outs;
  logic brake, pwm_pin, led_g, led_r, rel, fault;
  int err_count = 0;
  int checks = 0;
  int pulses = 0;
  int faults = 0;
  int f0 = 0;
  ////////////////////////////////////////
  dio_field_model dio_field_model_inst (.core_clk_i(core_clk_i), .switch_i(sw), .step_i(step),
    .pin_in_o(pins), .enc_o(enc), .count_o(cnt));
  dio_router #(.SAMPLE_CYCLES_P(SC)) dio_router_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .bus_req_i(bus), .bus_rdata_o(rdata), .pin_in_i(pins), .enc_i(enc), .net_active_i(net),
    .pwm_i(pwm), .encoder_count_value_i(cnt), .actual_position_value_i(cnt),
    .out_level_o(outs), .brake_o(brake), .pwm_pin_o(pwm_pin), .led_green_en_o(led_g),
    .led_red_en_o(led_r), .motion_release_o(rel), .interlock_fault_o(fault),
    .input_image_word_o(img));
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    pulses <= pulses + ((outs[1] === 1'b1) ? 1 : 0);
    faults <= faults + ((fault === 1'b1) ? 1 : 0);
  end
  ////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    bus.wr <= 1'b0;
  endtask
  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    bus.rd <= 1'b0;
    #1;
    chk(name, exp, rdata);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic pins_to(input logic [NUM_PIN-1:0] v);
    @(posedge core_clk_i);
    sw <= v;
    settle(3 * SC);
  endtask
  task automatic route(input logic [7:0] a, input logic [15:0] v, input logic [31:0] c,
                       input logic e);
    wr(a, {16'h0, v});
    wr(ADDR_CTRL_WORD, c);
    settle(2);
    chk("routed pin", {31'h0, e}, {31'h0, (a == ADDR_OUT_ROUTE_BASE) ? pwm_pin : outs[0]});
  endtask
  task automatic steps(input logic [15:0] v, input int exp);
    int p0;
    wr(ADDR_OUT_ROUTE_BASE + 8'h2, {16'h0, v});
    settle(3);
    p0 = pulses;
    repeat (8) begin
      @(posedge core_clk_i);
      step <= 1'b1;
      @(posedge core_clk_i);
      step <= 1'b0;
      settle(4);
    end
    chk("pulse count", 32'(exp), 32'(pulses - p0));
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge core_clk_i);
    chk("reset release", 32'h1, {31'h0, rel});
    rst_n_i <= 1'b1;
    rchk("route reset", ADDR_OUT_ROUTE_BASE, {16'h0, RST_ROUTE});
    rchk("unmapped", 8'h80, 32'h0);
    wr(ADDR_OUT_APPLIED, 32'hffff_ffff);
    rchk("applied ro", ADDR_OUT_APPLIED, 32'h0);
    wr(ADDR_OUT_UNUSED, 32'hffff_ffff);
    rchk("unused", ADDR_OUT_UNUSED, 32'h0);
    wr(ADDR_LED_CTRL, 32'h2);
    settle(1);
    chk("leds red", 32'h2, {30'h0, led_r, led_g});
    wr(ADDR_LED_CTRL, 32'h1);
    settle(1);
    chk("leds green", 32'h1, {30'h0, led_r, led_g});
    $display("test registers done");
    wr(ADDR_OUT_IMAGE, 32'h0001_0006);
    settle(2);
    chk("low bits", 32'h1, {29'h0, brake, outs});
    wr(ADDR_OUT_IMAGE, 32'h0001_0001);
    settle(2);
    chk("open drive", 32'h5, {29'h0, brake, outs});
    wr(ADDR_OUT_POL, 32'h0003_0000);
    settle(2);
    chk("closed drive", 32'h6, {29'h0, brake, outs});
    rchk("applied pol", ADDR_OUT_APPLIED, 32'h0002_0001);
    wr(ADDR_OUT_MAN_EN, 32'h0001_0001);
    wr(ADDR_OUT_MAN_VAL, 32'h0001_0000);
    settle(2);
    chk("manual", 32'h3, {29'h0, brake, outs});
    rchk("applied man", ADDR_OUT_APPLIED, 32'h0003_0000);
    $display("test output drive done");
    wr(ADDR_OUT_ROUTE_EN, 32'h1);
    settle(2);
    chk("routed idle", 32'h4, {29'h0, brake, outs});
    route(ADDR_OUT_ROUTE_BASE + 8'h1, 16'h0005, 32'h20, 1'b1);
    route(ADDR_OUT_ROUTE_BASE + 8'h1, 16'h0005, 32'h0, 1'b0);
    route(ADDR_OUT_ROUTE_BASE + 8'h1, 16'h0085, 32'h0, 1'b1);
    route(ADDR_OUT_ROUTE_BASE + 8'h1, 16'h0085, 32'h20, 1'b0);
    route(ADDR_OUT_ROUTE_BASE + 8'h1, 16'h0105, 32'h20, 1'b0);
    route(ADDR_OUT_ROUTE_BASE + 8'h1, 16'h3005, 32'h20, 1'b0);
    route(ADDR_OUT_ROUTE_BASE, 16'h1005, 32'h20, 1'b1);
    route(ADDR_OUT_ROUTE_BASE, 16'h1105, 32'h20, 1'b0);
    @(posedge core_clk_i);
    pwm <= 1'b0;
    route(ADDR_OUT_ROUTE_BASE, 16'h1005, 32'h20, 1'b0);
    route(ADDR_OUT_ROUTE_BASE, 16'h1105, 32'h20, 1'b1);
    wr(ADDR_CTRL_WORD, 32'h1);
    steps(16'h0200, 8);
    steps(16'h0400, 2);
    steps(16'h0900, 8);
    wr(ADDR_OUT_ROUTE_EN, 32'h0);
    settle(2);
    chk("routing off", 32'h0, {31'h0, brake});
    $display("test output routing done");
    pins_to(16'h0009);
    chk("image plain", 32'h0009_0009, img);
    wr(ADDR_IN_ROUTE_EN, 32'h1);
    settle(3 * SC);
    chk("image preload", 32'h0009_0009, img);
    wr(ADDR_IN_ROUTE_BASE, 32'h00);
    wr(ADDR_IN_ROUTE_BASE + 8'h1, 32'hb0);
    wr(ADDR_IN_ROUTE_BASE + 8'hc, 32'h45);
    wr(ADDR_IN_ROUTE_BASE + 8'hd, 32'hc6);
    wr(ADDR_IN_ROUTE_BASE + 8'h5, 32'h44);
    wr(ADDR_IN_ROUTE_BASE + 8'h6, 32'h80);
    wr(ADDR_IN_ROUTE_BASE + 8'h7, 32'h81);
    wr(ADDR_IN_ROUTE_BASE + 8'h8, 32'h48);
    wr(ADDR_IN_ROUTE_BASE + 8'h9, 32'h30);
    wr(ADDR_IN_ROUTE_BASE + 8'hb, 32'h90);
    settle(3 * SC);
    rdv = {16'h0009, 2'b00, ~enc.enc_idx, enc.enc_b, 4'h9, 2'b01, enc.enc_a, 5'h08};
    chk("image routed", rdv, img);
    $display("test input routing done");
    wr(ADDR_IN_SPECIAL, 32'h8);
    settle(3 * SC);
    chk("release on", 32'h1, {31'h0, rel});
    rchk("release run", ADDR_REL_STATE, 32'h1);
    f0 = faults;
    pins_to(16'h0001);
    chk("release off", 32'h0, {31'h0, rel});
    chk("fault pulses", 32'h1, 32'(faults - f0));
    rchk("release stop", ADDR_REL_STATE, 32'h2);
    pins_to(16'h0009);
    chk("release back", 32'h1, {31'h0, rel});
    wr(ADDR_IN_SPECIAL, 32'h0);
    pins_to(16'h0001);
    chk("release masked", 32'h1, {31'h0, rel});
    rchk("release idle", ADDR_REL_STATE, 32'h0);
    $display("test motion release done");
    print_verdict();
  end
endmodule
`default_nettype wire
